// *** rtl/rdlc_pkg.sv ***
// Package of constants and types for the radio demodulator loop configuration registers.
// ****************************************
// ****************************************
package rdlc_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [15:0] OFF_CAL_CFG = 16'hDF14;
	localparam logic [15:0] OFF_FOC_CFG = 16'hDF15;
	localparam logic [15:0] OFF_BS_CFG = 16'hDF16;
	localparam logic [15:0] OFF_STATUS = 16'hDFF0;

	// ****************************************
	// Reset values and writable masks
	// ****************************************
	localparam logic [7:0] RST_CAL_CFG = 8'h04;
	localparam logic [7:0] RST_FOC_CFG = 8'h76;
	localparam logic [7:0] RST_BS_CFG = 8'h6C;
	localparam logic [7:0] MASK_CAL_CFG = 8'h3F;
	localparam logic [7:0] MASK_FOC_CFG = 8'h7F;
	localparam logic [7:0] MASK_BS_CFG = 8'hFF;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CAL_SEL_LSB = 4;
	localparam int ATTEN_LSB = 0;
	localparam int FOC_GATE_BIT = 5;
	localparam int FOC_PRE_LSB = 3;
	localparam int FOC_POST_BIT = 2;
	localparam int FREQ_COMP_SATURATION_LSB = 0;
	localparam int CLOCK_REC_PRE_INTEGRAL_GAIN_LSB = 6;
	localparam int CLOCK_REC_PRE_PROPORTIONAL_GAIN_LSB = 4;
	localparam int CLOCK_REC_POST_INTEGRAL_GAIN_BIT = 3;
	localparam int CLOCK_REC_POST_PROPORTIONAL_GAIN_BIT = 2;
	localparam int DATA_RATE_COMP_SATURATION_LSB = 0;

	// ****************************************
	// Calibration modes and field scales
	// ****************************************
	typedef enum logic [1:0] {
		CAL_NEVER = 2'h0,
		CAL_FROM_IDLE = 2'h1,
		CAL_TO_IDLE = 2'h2,
		CAL_TO_IDLE_4TH = 2'h3
	} rdlc_cal_mode_t;
	localparam logic [1:0] CAL_EVERY_NTH_LAST = 2'h3;
	localparam logic [4:0] ATTEN_STEP_DB = 5'h06;
	localparam logic [6:0] DR_LIMIT_STEP = 7'h19;

	// Loop settings as seen by the demodulator.
	typedef struct packed {
		logic freq_freeze;
		logic clock_freeze;
		logic [3:0] freq_gain_half_k;
		logic [1:0] freq_limit_code;
		logic [3:0] int_gain_half_ki;
		logic [2:0] prop_gain_kp;
		logic [6:0] dr_limit_eighth_pct;
	} rdlc_loop_ctrl_t;
endpackage : rdlc_pkg

// *** rtl/rdlc_regs.sv ***
// Register bank and derived controls for the calibration and demodulator loop settings.
`timescale 1ns/1ps
`default_nettype none
module rdlc_regs (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// Register port
	input wire logic [rdlc_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [rdlc_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [rdlc_pkg::DATA_W-1:0] reg_rdata_o,
	// Radio state machine events
	input wire logic calibrate_strobe_i,
	input wire logic idle_to_active_i,
	input wire logic auto_return_idle_i,
	output logic cal_start_o,
	// Demodulator status
	input wire logic carrier_sense_i,
	input wire logic sync_found_i,
	// Front end and loop settings
	output logic [1:0] rx_atten_sel_o,
	output logic [4:0] rx_atten_db_o,
	output rdlc_pkg::rdlc_loop_ctrl_t loop_ctrl_o
);

	// ****************************************
	// Register storage
	// ****************************************
	logic [7:0] cal_cfg_r;
	logic [7:0] foc_cfg_r;
	logic [7:0] bs_cfg_r;
	logic [1:0] auto_cnt_r;
	rdlc_pkg::rdlc_cal_mode_t cal_mode;
	rdlc_pkg::rdlc_loop_ctrl_t loop_nxt;
	logic cal_nxt;
	logic [7:0] rdata_nxt;
	logic [7:0] status;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == off);
	endfunction : hit

	function automatic logic [2:0] times_code(input logic [1:0] code);
		times_code = {1'b0, code} + 3'h1;
	endfunction : times_code

	// Unused bits are masked away so they never store.
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			cal_cfg_r <= rdlc_pkg::RST_CAL_CFG;
		end else if (reg_wr_i && hit(reg_addr_i, rdlc_pkg::OFF_CAL_CFG)) begin
			cal_cfg_r <= reg_wdata_i & rdlc_pkg::MASK_CAL_CFG;
		end
	end

	// Reserved bit 6 keeps whatever software writes; it is expected to write zero.
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			foc_cfg_r <= rdlc_pkg::RST_FOC_CFG;
		end else if (reg_wr_i && hit(reg_addr_i, rdlc_pkg::OFF_FOC_CFG)) begin
			foc_cfg_r <= reg_wdata_i & rdlc_pkg::MASK_FOC_CFG;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			bs_cfg_r <= rdlc_pkg::RST_BS_CFG;
		end else if (reg_wr_i && hit(reg_addr_i, rdlc_pkg::OFF_BS_CFG)) begin
			bs_cfg_r <= reg_wdata_i & rdlc_pkg::MASK_BS_CFG;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	assign status = {4'h0, sync_found_i, loop_ctrl_o.freq_freeze, auto_cnt_r};

	always_comb begin
		rdata_nxt = 8'h00;
		if (hit(reg_addr_i, rdlc_pkg::OFF_CAL_CFG)) begin
			rdata_nxt = cal_cfg_r;
		end else if (hit(reg_addr_i, rdlc_pkg::OFF_FOC_CFG)) begin
			rdata_nxt = foc_cfg_r;
		end else if (hit(reg_addr_i, rdlc_pkg::OFF_BS_CFG)) begin
			rdata_nxt = bs_cfg_r;
		end else if (hit(reg_addr_i, rdlc_pkg::OFF_STATUS)) begin
			rdata_nxt = status;
		end
	end

	// Data stand for the one cycle after the strobe, zero otherwise.
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rdata_nxt;
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

	// ****************************************
	// Synthesizer calibration trigger
	// ****************************************
	assign cal_mode = rdlc_pkg::rdlc_cal_mode_t'(cal_cfg_r[rdlc_pkg::CAL_SEL_LSB +: 2]);

	// The counter only advances in the every-fourth mode, so switching into it starts a fresh count.
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			auto_cnt_r <= 2'h0;
		end else if (cal_mode != rdlc_pkg::CAL_TO_IDLE_4TH) begin
			auto_cnt_r <= 2'h0;
		end else if (auto_return_idle_i) begin
			auto_cnt_r <= auto_cnt_r + 2'h1;
		end
	end

	always_comb begin
		cal_nxt = calibrate_strobe_i;
		unique case (cal_mode)
			rdlc_pkg::CAL_NEVER: cal_nxt = calibrate_strobe_i;
			rdlc_pkg::CAL_FROM_IDLE: cal_nxt = calibrate_strobe_i | idle_to_active_i;
			rdlc_pkg::CAL_TO_IDLE: cal_nxt = calibrate_strobe_i | auto_return_idle_i;
			rdlc_pkg::CAL_TO_IDLE_4TH: cal_nxt = calibrate_strobe_i |
				(auto_return_idle_i && auto_cnt_r == rdlc_pkg::CAL_EVERY_NTH_LAST);
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			cal_start_o <= 1'b0;
		end else begin
			cal_start_o <= cal_nxt;
		end
	end

	// ****************************************
	// Receive attenuation
	// ****************************************
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			rx_atten_sel_o <= 2'h0;
			rx_atten_db_o <= 5'h00;
		end else begin
			rx_atten_sel_o <= cal_cfg_r[rdlc_pkg::ATTEN_LSB +: 2];
			rx_atten_db_o <= 5'(cal_cfg_r[rdlc_pkg::ATTEN_LSB +: 2] * rdlc_pkg::ATTEN_STEP_DB);
		end
	end

	// ****************************************
	// Demodulator loop settings
	// ****************************************
	// Freezing follows carrier sense as a level, so a lost carrier freezes the loops again.
	always_comb begin
		loop_nxt.freq_freeze = foc_cfg_r[rdlc_pkg::FOC_GATE_BIT] & ~carrier_sense_i;
		loop_nxt.clock_freeze = foc_cfg_r[rdlc_pkg::FOC_GATE_BIT] & ~carrier_sense_i;
		loop_nxt.freq_gain_half_k = {times_code(foc_cfg_r[rdlc_pkg::FOC_PRE_LSB +: 2]), 1'b0};
		if (sync_found_i && foc_cfg_r[rdlc_pkg::FOC_POST_BIT]) begin
			loop_nxt.freq_gain_half_k = 4'h1;
		end
		loop_nxt.freq_limit_code = foc_cfg_r[rdlc_pkg::FREQ_COMP_SATURATION_LSB +: 2];
		loop_nxt.int_gain_half_ki = {times_code(bs_cfg_r[rdlc_pkg::CLOCK_REC_PRE_INTEGRAL_GAIN_LSB +: 2]), 1'b0};
		if (sync_found_i && bs_cfg_r[rdlc_pkg::CLOCK_REC_POST_INTEGRAL_GAIN_BIT]) begin
			loop_nxt.int_gain_half_ki = 4'h1;
		end
		loop_nxt.prop_gain_kp = times_code(bs_cfg_r[rdlc_pkg::CLOCK_REC_PRE_PROPORTIONAL_GAIN_LSB +: 2]);
		if (sync_found_i && bs_cfg_r[rdlc_pkg::CLOCK_REC_POST_PROPORTIONAL_GAIN_BIT]) begin
			loop_nxt.prop_gain_kp = 3'h1;
		end
		loop_nxt.dr_limit_eighth_pct = 7'h00;
		unique case (bs_cfg_r[rdlc_pkg::DATA_RATE_COMP_SATURATION_LSB +: 2])
			2'h0: loop_nxt.dr_limit_eighth_pct = 7'h00;
			2'h1: loop_nxt.dr_limit_eighth_pct = rdlc_pkg::DR_LIMIT_STEP;
			2'h2: loop_nxt.dr_limit_eighth_pct = 7'(rdlc_pkg::DR_LIMIT_STEP << 1);
			2'h3: loop_nxt.dr_limit_eighth_pct = 7'(rdlc_pkg::DR_LIMIT_STEP << 2);
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			loop_ctrl_o <= '0;
		end else begin
			loop_ctrl_o <= loop_nxt;
		end
	end

endmodule : rdlc_regs
`default_nettype wire

// *** testbench/radio_demod_loop_config_regs_tb.sv ***
// Self-checking bench for the loop configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module radio_demod_loop_config_regs_tb;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [2:0] ev = 3'h0;
	logic carrier = 1'b0;
	logic sync = 1'b0;
	logic [7:0] rdata;
	logic cal;
	logic [1:0] asel;
	logic [4:0] adb;
	rdlc_pkg::rdlc_loop_ctrl_t lc;
	int failures = 0;
	int compares = 0;
	int ncal = 0;
	int cyc = 0;
	int drx[4] = '{0, 25, 50, 100};
	int calx[4] = '{1, 2, 5, 2};
	always #5 clk_sys_i = ~clk_sys_i;
	rdlc_regs rdlc_regs_inst (.clk_sys_i, .resetn_i, .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(rdata), .calibrate_strobe_i(ev[0]), .idle_to_active_i(ev[1]),
		.auto_return_idle_i(ev[2]), .cal_start_o(cal), .carrier_sense_i(carrier), .sync_found_i(sync),
		.rx_atten_sel_o(asel), .rx_atten_db_o(adb), .loop_ctrl_o(lc));
	// ****************************************
	// Access and checking tasks
	// ****************************************
	task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, exp, got);
		end
	endtask : chk
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_i);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk_sys_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		#1 chk("rdata", rdata, exp);
	endtask : rd_reg
	task automatic pulse(input logic [2:0] e);
		@(posedge clk_sys_i);
		ev <= e;
		@(posedge clk_sys_i);
		ev <= 3'h0;
		repeat (2) @(posedge clk_sys_i);
	endtask : pulse
	// Register writes reach the loop outputs one edge later, so two edges cover it.
	task automatic settle();
		repeat (2) @(posedge clk_sys_i);
		#1;
	endtask : settle
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	always @(posedge clk_sys_i) begin
		if (cal === 1'b1)
			ncal++;
		cyc++;
		if (cyc == 5000) begin
			failures++;
			final_report();
		end
	end
	initial begin
		repeat (20) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		settle();
		chk("freeze", 8'(lc.freq_freeze), 8'h01);
		chk("fgain", 8'(lc.freq_gain_half_k), 8'h06);
		chk("flimit", 8'(lc.freq_limit_code), 8'h02);
		chk("igain", 8'(lc.int_gain_half_ki), 8'h04);
		chk("pgain", 8'(lc.prop_gain_kp), 8'h03);
		chk("drlim", 8'(lc.dr_limit_eighth_pct), 8'h00);
		rd_reg(16'hDF14, 8'h04);
		rd_reg(16'hDF15, 8'h76);
		rd_reg(16'hDF16, 8'h6C);
		rd_reg(16'hDF17, 8'h00);
		wr_reg(16'hDF14, 8'hFF);
		rd_reg(16'hDF14, 8'h3F);
		wr_reg(16'hDF15, 8'hBF);
		rd_reg(16'hDF15, 8'h3F);
		for (int i = 0; i < 4; i++) begin
			wr_reg(16'hDF14, 8'(i));
			settle();
			chk("atten", 8'(adb), 8'(i * 6));
			chk("asel", 8'(asel), 8'(i));
			wr_reg(16'hDF15, 8'(i * 9));
			settle();
			chk("fgain", 8'(lc.freq_gain_half_k), 8'(i * 2 + 2));
			chk("flimit", 8'(lc.freq_limit_code), 8'(i));
			wr_reg(16'hDF16, 8'(i * 8'h51));
			sync <= 1'b1;
			settle();
			chk("fpost", 8'(lc.freq_gain_half_k), 8'(i * 2 + 2));
			chk("ipost", 8'(lc.int_gain_half_ki), 8'(i * 2 + 2));
			chk("ppost", 8'(lc.prop_gain_kp), 8'(i + 1));
			chk("drlim", 8'(lc.dr_limit_eighth_pct), 8'(drx[i]));
			sync <= 1'b0;
			settle();
			chk("igain", 8'(lc.int_gain_half_ki), 8'(i * 2 + 2));
			chk("pgain", 8'(lc.prop_gain_kp), 8'(i + 1));
		end
		wr_reg(16'hDF15, 8'h24);
		wr_reg(16'hDF16, 8'hFC);
		sync <= 1'b1;
		settle();
		chk("fhalf", 8'(lc.freq_gain_half_k), 8'h01);
		chk("ihalf", 8'(lc.int_gain_half_ki), 8'h01);
		chk("pone", 8'(lc.prop_gain_kp), 8'h01);
		chk("frz", 8'({lc.freq_freeze, lc.clock_freeze}), 8'h03);
		carrier <= 1'b1;
		settle();
		chk("thaw", 8'({lc.freq_freeze, lc.clock_freeze}), 8'h00);
		for (int m = 0; m < 4; m++) begin
			wr_reg(16'hDF14, 8'(m * 16));
			ncal = 0;
			pulse(3'h1);
			pulse(3'h2);
			repeat (4) pulse(3'h4);
			chk("cals", 8'(ncal), 8'(calx[m]));
		end
		// Four returns wrap the count to zero; carrier thaws the loops and sync is still high.
		rd_reg(16'hDFF0, 8'h08);
		final_report();
	end
endmodule : radio_demod_loop_config_regs_tb
`default_nettype wire

// *** testbench/rdlc_regs_assertions.sv ***
// Assertions on the ports of the loop configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module rdlc_regs_assertions (
	// Watched ports
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic [rdlc_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [rdlc_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [rdlc_pkg::DATA_W-1:0] reg_rdata_o,
	input wire logic calibrate_strobe_i,
	input wire logic idle_to_active_i,
	input wire logic auto_return_idle_i,
	input wire logic cal_start_o,
	input wire logic carrier_sense_i,
	input wire logic [1:0] rx_atten_sel_o,
	input wire logic [4:0] rx_atten_db_o,
	input wire rdlc_pkg::rdlc_loop_ctrl_t loop_ctrl_o
);
	// Shadow of the mode field, updated at the same edge as the register itself.
	logic [1:0] mode_r;
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i)
			mode_r <= 2'h0;
		else if (reg_wr_i && reg_addr_i == rdlc_pkg::OFF_CAL_CFG)
			mode_r <= reg_wdata_i[5:4];
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	a_strobe_cal: assert property (calibrate_strobe_i |=> cal_start_o) else $error("strobe gave no calibration");
	a_never_quiet: assert property (mode_r == 2'h0 && !calibrate_strobe_i |=> !cal_start_o)
		else $error("calibration in manual mode");
	a_leave_idle: assert property (mode_r == 2'h1 && idle_to_active_i |=> cal_start_o)
		else $error("no calibration leaving idle");
	a_return_cal: assert property (mode_r == 2'h2 && auto_return_idle_i |=> cal_start_o)
		else $error("no calibration on return");
	a_cal_cause: assert property (!(calibrate_strobe_i || idle_to_active_i || auto_return_idle_i) |=> !cal_start_o)
		else $error("calibration without event");
	a_atten_scale: assert property (rx_atten_db_o == 5'(rx_atten_sel_o) * 5'h06) else $error("attenuation mismatch");
	a_carrier_thaw: assert property (carrier_sense_i |=> !loop_ctrl_o.freq_freeze && !loop_ctrl_o.clock_freeze)
		else $error("loops frozen with carrier");
	a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("read data outside slot");
	a_unused_zero: assert property (reg_rd_i && reg_addr_i == rdlc_pkg::OFF_CAL_CFG |=> reg_rdata_o[7:6] == 2'h0)
		else $error("unused bits not zero");
endmodule : rdlc_regs_assertions
bind rdlc_regs rdlc_regs_assertions rdlc_regs_assertions_inst (.clk_sys_i, .resetn_i, .reg_addr_i, .reg_wdata_i,
	.reg_wr_i, .reg_rd_i, .reg_rdata_o, .calibrate_strobe_i, .idle_to_active_i, .auto_return_idle_i,
	.cal_start_o, .carrier_sense_i, .rx_atten_sel_o, .rx_atten_db_o, .loop_ctrl_o);
`default_nettype wire
